//--- hdl/acc_top.sv
// Calibration control registers, sequencer, status pin and interrupt
//
// Operation
// - Background offset runs only when its bit and background calibration are set.
// - Foreground offset runs only when its bit and foreground calibration are set.
// - Background bit 0 disables background calibration, 1 runs it continuously; reset 0.
// - Each run clears stored values, then runs or skips foreground per its bit.
// - Without background, core select picks the core kept offline; code 3 reserved.
// - Offset averaging field sets offset routine length; larger means more averaging.
// - Linearity averaging field sets linearity routine length; larger means more averaging.
// - Stopped bit rises when background halts at phase end, falls on resume.
// - Without background, stopped bit sets when foreground finishes or is skipped.
// - Foreground-complete bit is high once foreground finished or was skipped.
// - Status register is read-only; contents meaningless before calibration runs.
// - Status pin select mirrors done, stopped, alarm, or holds pin low.
// - Trigger source bit picks software bit or trigger pin, ignoring the other.
// - Calibration enable starts calibration; clearing holds it and resets dividers.
// - Software trigger bit replaces the pin; left high keeps trigger asserted.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module acc_top
   import acc_pkg::*;
#(
   parameter int unsigned LIN_BASE_CYC = 16,
   parameter int unsigned OS_BASE_CYC = 8
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Register port
   input wire acc_req_t REQ,
   output logic [DATA_W-1:0] RD_DATA,
   // Pins
   input wire logic TRIG_PIN,
   input wire logic ALARM_PIN,
   output logic STATUS_PIN,
   // Interrupt
   output logic IRQ,
   // Controls to the converter cores
   output logic [NUM_CORES-1:0] OFFLINE_CORE_MASK,
   output logic CLEAR_VALUES,
   output logic LIN_ACTIVE,
   output logic OS_ACTIVE,
   output logic BG_ACTIVE,
   output logic DIV_RST,
   output logic LINK_EN
);

   // --------------------------------------------------------------------
   // Register file
   // --------------------------------------------------------------------
   logic [DATA_W-1:0] cal_en_q, cfg_q, core_q, avg_q, pin_q, soft_q, link_q;
   logic [IRQ_W-1:0] irq_mask_q, irq_stat_q, irq_stat_d;
   logic [DATA_W-1:0] rd_data_d, stat_reg;
   wire wr_cal_en = REQ.wr && (REQ.addr == OFS_CAL_ENABLE);
   wire wr_cfg = REQ.wr && (REQ.addr == OFS_CONFIG_MAIN);
   wire wr_core = REQ.wr && (REQ.addr == OFS_CORE_SELECT);
   wire wr_avg = REQ.wr && (REQ.addr == OFS_AVERAGING);
   wire wr_pin = REQ.wr && (REQ.addr == OFS_PIN_SETUP);
   wire wr_soft = REQ.wr && (REQ.addr == OFS_SOFT_TRIG);
   wire wr_link = REQ.wr && (REQ.addr == OFS_LINK_CTRL);
   wire wr_mask = REQ.wr && (REQ.addr == OFS_IRQ_MASK);
   wire rd_irq = REQ.rd && (REQ.addr == OFS_IRQ_STATUS);

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cal_en_q <= RST_CAL_ENABLE;
         cfg_q <= RST_CONFIG_MAIN;
         core_q <= RST_CORE_SELECT;
         avg_q <= RST_AVERAGING;
         pin_q <= RST_PIN_SETUP;
         soft_q <= RST_SOFT_TRIG;
         link_q <= RST_LINK_CTRL;
         irq_mask_q <= IRQ_W'(RST_IRQ_MASK);
      end
      else
      begin
         // Status register has no write decode: writes to it are dropped
         if (wr_cal_en) cal_en_q <= REQ.wdata;
         if (wr_cfg) cfg_q <= REQ.wdata;
         if (wr_core) core_q <= REQ.wdata;
         if (wr_avg) avg_q <= REQ.wdata;
         if (wr_pin) pin_q <= REQ.wdata;
         if (wr_soft) soft_q <= REQ.wdata;
         if (wr_link) link_q <= REQ.wdata;
         if (wr_mask) irq_mask_q <= REQ.wdata[IRQ_W-1:0];
      end
   end

   wire cal_en = cal_en_q[BIT_CAL_EN];
   wire fg_en = cfg_q[BIT_FG];
   wire bg_en = cfg_q[BIT_BG];
   wire fg_os_en = cfg_q[BIT_FG_OS];
   wire bg_os_en = cfg_q[BIT_BG_OS];
   wire [2:0] lin_avg = avg_q[LIN_AVG_LSB +: 3];
   wire [2:0] offset_averaging = avg_q[OFFSET_AVERAGING_LSB +: 3];
   wire [1:0] core_sel = core_q[CORE_SEL_LSB +: 2];
   wire [1:0] pin_sel = pin_q[PIN_SEL_LSB +: 2];

   // --------------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------------
   logic trig_m_q, trig_s_q, alarm_m_q, alarm_s_q, alarm_old_q;
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         trig_m_q <= 1'b0;
         trig_s_q <= 1'b0;
         alarm_m_q <= 1'b0;
         alarm_s_q <= 1'b0;
         alarm_old_q <= 1'b0;
      end
      else
      begin
         trig_m_q <= TRIG_PIN;
         trig_s_q <= trig_m_q;
         alarm_m_q <= ALARM_PIN;
         alarm_s_q <= alarm_m_q;
         alarm_old_q <= alarm_s_q;
      end
   end

   // Unused source is fully masked so a floating pin cannot start a run
   wire trig = pin_q[PIN_TRIG_SRC] ? trig_s_q : soft_q[BIT_SOFT_TRIG];

   // --------------------------------------------------------------------
   // Calibration sequencer
   // --------------------------------------------------------------------
   acc_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [1:0] bg_core_q, bg_core_d;
   // Longest run is base << 7; base must stay below 2**(CNT_W-7)
   wire [CNT_W-1:0] lin_len = CNT_W'(LIN_BASE_CYC) << lin_avg;
   wire [CNT_W-1:0] os_len = CNT_W'(OS_BASE_CYC) << offset_averaging;
   wire phase_end = (cnt_q == '0);

   always_comb
   begin
      state_d = state_q;
      cnt_d = phase_end ? cnt_q : cnt_q - 1'b1;
      bg_core_d = bg_core_q;
      case (state_q)
         S_HOLD: if (cal_en) state_d = S_CLEAR;
         S_CLEAR:
         begin
            // Stored values are wiped here whatever the foreground bit says
            if (fg_en) state_d = S_WAIT_TRIG;
            else if (bg_en)
            begin
               state_d = S_BG_LIN;
               cnt_d = lin_len;
            end
            else state_d = S_FOREGROUND_COMPLETE;
         end
         S_WAIT_TRIG:
         begin
            if (trig)
            begin
               state_d = S_LIN;
               cnt_d = lin_len;
            end
         end
         S_LIN:
         begin
            if (phase_end)
            begin
               if (fg_os_en && fg_en)
               begin
                  state_d = S_OFS;
                  cnt_d = os_len;
               end
               else if (bg_en)
               begin
                  state_d = S_BG_LIN;
                  cnt_d = lin_len;
               end
               else state_d = S_FOREGROUND_COMPLETE;
            end
         end
         S_OFS:
         begin
            if (phase_end)
            begin
               if (bg_en)
               begin
                  state_d = S_BG_LIN;
                  cnt_d = lin_len;
               end
               else state_d = S_FOREGROUND_COMPLETE;
            end
         end
         S_FOREGROUND_COMPLETE:
         begin
            if (bg_en)
            begin
               state_d = S_BG_LIN;
               cnt_d = lin_len;
            end
         end
         S_BG_LIN, S_BG_OFS:
         begin
            // Clearing the background bit stops it at once, not at the phase end
            if (!bg_en) state_d = S_FOREGROUND_COMPLETE;
            else if (phase_end)
            begin
               if (state_q == S_BG_LIN) bg_core_d = (bg_core_q == 2'(NUM_CORES - 1)) ? 2'h0 : bg_core_q + 2'h1;
               if (state_q == S_BG_LIN && bg_os_en)
               begin
                  state_d = S_BG_OFS;
                  cnt_d = os_len;
               end
               else if (!trig) state_d = S_BG_STOP;
               else
               begin
                  state_d = S_BG_LIN;
                  cnt_d = lin_len;
               end
            end
         end
         S_BG_STOP:
         begin
            if (!bg_en) state_d = S_FOREGROUND_COMPLETE;
            else if (trig)
            begin
               state_d = S_BG_LIN;
               cnt_d = lin_len;
            end
         end
         default: state_d = S_HOLD;
      endcase
      // Clearing the enable aborts any phase at once
      if (!cal_en)
      begin
         state_d = S_HOLD;
         cnt_d = '0;
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_q <= S_HOLD;
         cnt_q <= '0;
         bg_core_q <= 2'h0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bg_core_q <= bg_core_d;
      end
   end

   // --------------------------------------------------------------------
   // Status and outputs
   // --------------------------------------------------------------------
   logic [2:0] stat_code;
   always_comb
   begin
      case (state_q)
         S_HOLD: stat_code = 3'h0;
         S_CLEAR: stat_code = 3'h1;
         S_WAIT_TRIG: stat_code = 3'h2;
         S_LIN: stat_code = 3'h3;
         S_OFS: stat_code = 3'h4;
         S_FOREGROUND_COMPLETE: stat_code = 3'h5;
         S_BG_STOP: stat_code = 3'h7;
         default: stat_code = 3'h6;
      endcase
   end

   wire bg_run = (state_q == S_BG_LIN) || (state_q == S_BG_OFS) || (state_q == S_BG_STOP);
   wire foreground_complete = (state_q == S_FOREGROUND_COMPLETE) || bg_run;
   wire stopped = (state_q == S_FOREGROUND_COMPLETE) || (state_q == S_BG_STOP);
   wire alarm_rise = alarm_s_q && !alarm_old_q;
   assign stat_reg = {3'h0, stat_code, stopped, foreground_complete};

   logic status_pin_d;
   always_comb
   begin
      case (pin_sel)
         PSEL_FOREGROUND_COMPLETE: status_pin_d = foreground_complete;
         PSEL_STOPPED: status_pin_d = stopped;
         PSEL_ALARM: status_pin_d = alarm_s_q;
         default: status_pin_d = 1'b0;
      endcase
   end

   // Background rotates the offline core; otherwise the selected core stays out
   logic [NUM_CORES-1:0] mask_d;
   genvar g;
   generate
      for (g = 0; g < NUM_CORES; g++)
      begin : g_core
         assign mask_d[g] = bg_run ? (bg_core_q == 2'(g)) : (core_sel == 2'(g));
      end
   endgenerate

   assign rd_data_d =
      (REQ.addr == OFS_CAL_ENABLE) ? cal_en_q :
      (REQ.addr == OFS_CONFIG_MAIN) ? cfg_q :
      (REQ.addr == OFS_CORE_SELECT) ? core_q :
      (REQ.addr == OFS_AVERAGING) ? avg_q :
      (REQ.addr == OFS_STATE) ? stat_reg :
      (REQ.addr == OFS_PIN_SETUP) ? pin_q :
      (REQ.addr == OFS_SOFT_TRIG) ? soft_q :
      (REQ.addr == OFS_LINK_CTRL) ? link_q :
      (REQ.addr == OFS_IRQ_STATUS) ? {5'h0, irq_stat_q} :
      (REQ.addr == OFS_IRQ_MASK) ? {5'h0, irq_mask_q} : 8'h00;

   // Previous-cycle flags give the rising edges; a new event beats the read clear
   logic foreground_complete_q, stopped_q;
   wire [IRQ_W-1:0] irq_ev = {alarm_rise, stopped && !stopped_q, foreground_complete && !foreground_complete_q};
   assign irq_stat_d = (rd_irq ? {IRQ_W{1'b0}} : irq_stat_q) | irq_ev;

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         RD_DATA <= 8'h00;
         STATUS_PIN <= 1'b0;
         IRQ <= 1'b0;
         irq_stat_q <= '0;
         foreground_complete_q <= 1'b0;
         stopped_q <= 1'b0;
         OFFLINE_CORE_MASK <= '0;
         CLEAR_VALUES <= 1'b0;
         LIN_ACTIVE <= 1'b0;
         OS_ACTIVE <= 1'b0;
         BG_ACTIVE <= 1'b0;
         DIV_RST <= 1'b1;
         LINK_EN <= 1'b0;
      end
      else
      begin
         RD_DATA <= REQ.rd ? rd_data_d : 8'h00;
         STATUS_PIN <= status_pin_d;
         IRQ <= |(irq_stat_d & irq_mask_q);
         irq_stat_q <= irq_stat_d;
         foreground_complete_q <= foreground_complete;
         stopped_q <= stopped;
         OFFLINE_CORE_MASK <= mask_d;
         CLEAR_VALUES <= (state_q == S_CLEAR);
         LIN_ACTIVE <= (state_q == S_LIN) || (state_q == S_BG_LIN);
         OS_ACTIVE <= (state_q == S_OFS) || (state_q == S_BG_OFS);
         BG_ACTIVE <= (state_q == S_BG_LIN) || (state_q == S_BG_OFS);
         DIV_RST <= !cal_en;
         LINK_EN <= link_q[BIT_LINK_EN];
      end
   end

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_enter_bg_ofs;
      (state_q == S_BG_OFS) && ($past(state_q) != S_BG_OFS);
   endsequence
   sequence s_enter_ofs;
      (state_q == S_OFS) && ($past(state_q) != S_OFS);
   endsequence
   sequence s_skip_all;
      (state_q == S_CLEAR) && !fg_en && !bg_en && cal_en;
   endsequence

   a_bg_offset_gate: assert property (s_enter_bg_ofs |-> $past(bg_os_en && bg_en))
      else $error("background offset ran without both enables");
   a_fg_offset_gate: assert property (s_enter_ofs |-> $past(fg_os_en && fg_en))
      else $error("foreground offset ran without its enables");
   a_bg_disabled: assert property (!bg_en && !$past(bg_en) |-> !(state_q == S_BG_LIN))
      else $error("background ran while disabled");
   a_clear_first: assert property ((state_q == S_HOLD) && cal_en |=> ##1 CLEAR_VALUES)
      else $error("calibration start did not clear values");
   a_skip_done: assert property (s_skip_all |=> foreground_complete && stopped ##1 STATUS_PIN || pin_sel != PSEL_FOREGROUND_COMPLETE)
      else $error("skipped foreground did not flag done and stopped");
   a_pin_low: assert property ((pin_sel == 2'h3) [*2] |=> !STATUS_PIN)
      else $error("status pin not held low");
   a_soft_trig: assert property ((state_q == S_WAIT_TRIG) && !pin_q[PIN_TRIG_SRC] && soft_q[BIT_SOFT_TRIG] && cal_en
      |=> state_q == S_LIN)
      else $error("software trigger did not start the run");
   a_hold_clears: assert property ($fell(cal_en) |=> !foreground_complete ##1 DIV_RST)
      else $error("done bit or divider reset wrong after enable cleared");
   a_bg_resume: assert property ((state_q == S_BG_STOP) && trig && bg_en && cal_en |=> !stopped)
      else $error("stopped bit stayed high on resume");
   a_lin_length: assert property ((state_q == S_WAIT_TRIG) && trig && cal_en |=> cnt_q == $past(lin_len))
      else $error("linearity phase length wrong");

endmodule
`default_nettype wire

//--- hdl/acc_pkg.sv
// Constants, types and register map of the calibration control block
package acc_pkg;

   // --------------------------------------------------------------------
   // Bus widths and carrier
   // --------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } acc_req_t;

   // --------------------------------------------------------------------
   // Register offsets
   // --------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CAL_ENABLE = 8'h61;
   localparam logic [ADDR_W-1:0] OFS_CONFIG_MAIN = 8'h62;
   localparam logic [ADDR_W-1:0] OFS_CORE_SELECT = 8'h64;
   localparam logic [ADDR_W-1:0] OFS_AVERAGING = 8'h68;
   localparam logic [ADDR_W-1:0] OFS_STATE = 8'h6a;
   localparam logic [ADDR_W-1:0] OFS_PIN_SETUP = 8'h6b;
   localparam logic [ADDR_W-1:0] OFS_SOFT_TRIG = 8'h6c;
   localparam logic [ADDR_W-1:0] OFS_LINK_CTRL = 8'h70;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h71;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h72;

   // --------------------------------------------------------------------
   // Reset values
   // --------------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_CAL_ENABLE = 8'h01;
   localparam logic [DATA_W-1:0] RST_CONFIG_MAIN = 8'h01;
   localparam logic [DATA_W-1:0] RST_CORE_SELECT = 8'h02;
   localparam logic [DATA_W-1:0] RST_AVERAGING = 8'h61;
   localparam logic [DATA_W-1:0] RST_PIN_SETUP = 8'h00;
   localparam logic [DATA_W-1:0] RST_SOFT_TRIG = 8'h01;
   localparam logic [DATA_W-1:0] RST_LINK_CTRL = 8'h00;
   localparam logic [DATA_W-1:0] RST_IRQ_MASK = 8'h00;

   // --------------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------------
   localparam int BIT_CAL_EN = 0;
   localparam int BIT_FG = 0;
   localparam int BIT_BG = 1;
   localparam int BIT_FG_OS = 2;
   localparam int BIT_BG_OS = 3;
   localparam int CORE_SEL_LSB = 0;
   localparam int LIN_AVG_LSB = 0;
   localparam int OFFSET_AVERAGING_LSB = 4;
   localparam int STAT_FOREGROUND_COMPLETE = 0;
   localparam int STAT_STOPPED = 1;
   localparam int STAT_CODE_LSB = 2;
   localparam int PIN_TRIG_SRC = 0;
   localparam int PIN_SEL_LSB = 1;
   localparam int BIT_SOFT_TRIG = 0;
   localparam int BIT_LINK_EN = 0;
   localparam int IRQ_W = 3;
   localparam int IRQ_FG = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_ALARM = 2;
   localparam int NUM_CORES = 3;
   localparam int CNT_W = 16;

   // --------------------------------------------------------------------
   // Codes and states
   // --------------------------------------------------------------------
   localparam logic [1:0] PSEL_FOREGROUND_COMPLETE = 2'h0;
   localparam logic [1:0] PSEL_STOPPED = 2'h1;
   localparam logic [1:0] PSEL_ALARM = 2'h2;

   typedef enum logic [3:0] {
      S_HOLD, S_CLEAR, S_WAIT_TRIG, S_LIN, S_OFS, S_FOREGROUND_COMPLETE, S_BG_LIN, S_BG_OFS, S_BG_STOP
   } acc_state_t;

endpackage

//--- verif/acc_top_tb_top.sv
// Self-checking testbench for the calibration control block
`timescale 1ns/10ps
`default_nettype none
module acc_top_tb_top
   import acc_pkg::*;
();
   // ---------------------------------------------------------------
   // Signals and counters
   // ---------------------------------------------------------------
   logic clk;
   logic rst_b;
   acc_req_t req;
   logic [7:0] rd_data;
   logic trig_pin;
   logic alarm_pin;
   logic status_pin;
   logic irq;
   logic [2:0] offline;
   logic clear_values;
   logic lin_active;
   logic os_active;
   logic bg_active;
   logic div_rst;
   logic link_en;
   int bad_count = 0;
   int tests_run = 0;
   int lin_n = 0;
   int os_n = 0;
   int bg_n = 0;
   int clr_n = 0;
   int s_lin;
   int s_os;
   int s_bg;
   int s_clr;

   // Short base counts keep each routine a few cycles long
   acc_top #(.LIN_BASE_CYC(2), .OS_BASE_CYC(2)) u_acc_top (
      .CLK(clk), .RST_B(rst_b), .REQ(req), .RD_DATA(rd_data), .TRIG_PIN(trig_pin), .ALARM_PIN(alarm_pin),
      .STATUS_PIN(status_pin), .IRQ(irq), .OFFLINE_CORE_MASK(offline), .CLEAR_VALUES(clear_values),
      .LIN_ACTIVE(lin_active), .OS_ACTIVE(os_active), .BG_ACTIVE(bg_active), .DIV_RST(div_rst),
      .LINK_EN(link_en));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Phase lengths are judged from running totals, so no task has to race the monitor
   always @(posedge clk)
   begin
      if (lin_active === 1'b1) lin_n++;
      if (os_active === 1'b1) os_n++;
      if (bg_active === 1'b1) bg_n++;
      if (clear_values === 1'b1) clr_n++;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic conclude();
      if (bad_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string msg, input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: %s got %h wanted %h", $time, msg, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rd_data;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      rd(a, d);
      chk(msg, d, exp);
   endtask

   task automatic wait_code(input logic [2:0] c);
      logic [7:0] d;
      int i;
      d = 8'h00;
      for (i = 0; i < 400 && d[4:2] !== c; i++)
         rd(OFS_STATE, d);
      chk("state code", {5'h00, d[4:2]}, {5'h00, c});
   endtask

   task automatic restart(input logic [7:0] cfg, input logic [7:0] avg);
      logic [7:0] d;
      wr(OFS_CAL_ENABLE, 8'h00);
      rd(OFS_STATE, d);
      chk("done while held", {7'h00, d[0]}, 8'h00);
      chk("divider reset", {7'h00, div_rst}, 8'h01);
      wr(OFS_CONFIG_MAIN, cfg);
      wr(OFS_AVERAGING, avg);
      chk_rd(OFS_AVERAGING, avg, "averaging readback");
      s_lin = lin_n;
      s_os = os_n;
      s_bg = bg_n;
      s_clr = clr_n;
      wr(OFS_CAL_ENABLE, 8'h01);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] ad [9] = '{OFS_CAL_ENABLE, OFS_CONFIG_MAIN, OFS_CORE_SELECT, OFS_AVERAGING, OFS_PIN_SETUP,
                             OFS_SOFT_TRIG, OFS_LINK_CTRL, OFS_IRQ_MASK, 8'h7f};
      logic [7:0] rv [9] = '{8'h01, 8'h01, 8'h02, 8'h61, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
      foreach (ad[i])
         chk_rd(ad[i], rv[i], "reset value");
      cyc(1);
      chk("read data idle", rd_data, 8'h00);
      wr(OFS_IRQ_MASK, 8'hff);
      chk_rd(OFS_IRQ_MASK, 8'h07, "mask width");
   endtask

   task automatic t_fg();
      logic [7:0] cf [3] = '{8'h05, 8'h05, 8'h01};
      logic [7:0] av [3] = '{8'h00, 8'h12, 8'h21};
      foreach (cf[i])
      begin
         restart(cf[i], av[i]);
         wait_code(3'h5);
         chk("clear pulses", 8'(clr_n - s_clr), 8'h01);
         chk("linearity length", 8'(lin_n - s_lin), 8'((2 << av[i][2:0]) + 1));
         chk("offset length", 8'(os_n - s_os), 8'(cf[i][2] ? (2 << av[i][6:4]) + 1 : 0));
         chk_rd(OFS_STATE, 8'h17, "done state");
      end
      restart(8'h00, 8'h61);
      wait_code(3'h5);
      chk("clear on skip", 8'(clr_n - s_clr), 8'h01);
      chk("no linearity", 8'(lin_n - s_lin), 8'h00);
      wr(OFS_STATE, 8'h00);
      chk_rd(OFS_STATE, 8'h17, "read-only state");
   endtask

   task automatic t_trig();
      wr(OFS_PIN_SETUP, 8'h01);
      restart(8'h01, 8'h00);
      wait_code(3'h2);
      cyc(20);
      chk_rd(OFS_STATE, 8'h08, "soft bit ignored");
      @(posedge clk);
      trig_pin <= 1'b1;
      wait_code(3'h5);
      wr(OFS_PIN_SETUP, 8'h00);
      wr(OFS_SOFT_TRIG, 8'h00);
      restart(8'h01, 8'h00);
      wait_code(3'h2);
      cyc(20);
      chk_rd(OFS_STATE, 8'h08, "pin ignored");
      wr(OFS_SOFT_TRIG, 8'h01);
      wait_code(3'h5);
   endtask

   task automatic t_pin();
      for (int s = 0; s < 4; s++)
         for (int a = 0; a < 2; a++)
         begin
            @(posedge clk);
            alarm_pin <= 1'(a);
            wr(OFS_PIN_SETUP, 8'(s << 1));
            cyc(4);
            chk("status pin", {7'h00, status_pin}, 8'(s < 2 ? 1 : (s == 2 ? a : 0)));
         end
      // Alarm returns low so that a later scenario can raise a fresh edge
      @(posedge clk);
      alarm_pin <= 1'b0;
      wr(OFS_PIN_SETUP, 8'h00);
   endtask

   task automatic t_core();
      // Link stays disabled here, as software must keep it while moving the core select
      for (int c = 0; c < 4; c++)
      begin
         wr(OFS_CORE_SELECT, 8'(c));
         cyc(2);
         chk("offline core", {5'h00, offline}, 8'(c == 3 ? 0 : 1 << c));
      end
      wr(OFS_CORE_SELECT, 8'h02);
   endtask

   task automatic t_bg();
      restart(8'h0a, 8'h00);
      wait_code(3'h6);
      cyc(60);
      chk("background ran", 8'(bg_n > s_bg), 8'h01);
      chk("background offset ran", 8'(os_n > s_os), 8'h01);
      wr(OFS_PIN_SETUP, 8'h02);
      cyc(4);
      chk("stopped on pin", {7'h00, status_pin}, 8'h00);
      wr(OFS_PIN_SETUP, 8'h00);
      wr(OFS_LINK_CTRL, 8'h01);
      cyc(2);
      chk("link enable", {7'h00, link_en}, 8'h01);
      wr(OFS_LINK_CTRL, 8'h00);
      wr(OFS_SOFT_TRIG, 8'h00);
      wait_code(3'h7);
      chk_rd(OFS_STATE, 8'h1f, "halted state");
      wr(OFS_SOFT_TRIG, 8'h01);
      wait_code(3'h6);
      chk_rd(OFS_STATE, 8'h19, "resumed state");
      restart(8'h02, 8'h00);
      wait_code(3'h6);
      cyc(60);
      chk("no background offset", 8'(os_n - s_os), 8'h00);
      restart(8'h09, 8'h00);
      wait_code(3'h5);
      chk("offset needs background", 8'(os_n - s_os + bg_n - s_bg), 8'h00);
   endtask

   task automatic t_irq();
      logic [7:0] d;
      rd(OFS_IRQ_STATUS, d);
      wr(OFS_IRQ_MASK, 8'h07);
      restart(8'h00, 8'h61);
      wait_code(3'h5);
      cyc(2);
      chk("irq raised", {7'h00, irq}, 8'h01);
      chk_rd(OFS_IRQ_STATUS, 8'h03, "irq events");
      chk("irq cleared", {7'h00, irq}, 8'h00);
      chk_rd(OFS_IRQ_STATUS, 8'h00, "irq read clears");
      wr(OFS_IRQ_MASK, 8'h00);
      @(posedge clk);
      alarm_pin <= 1'b1;
      cyc(6);
      chk("irq masked", {7'h00, irq}, 8'h00);
      chk_rd(OFS_IRQ_STATUS, 8'h04, "alarm sticky");
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      rst_b = 1'b0;
      req = '0;
      trig_pin = 1'b0;
      alarm_pin = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      cyc(1);
      t_reset();
      t_fg();
      t_trig();
      t_pin();
      t_core();
      t_bg();
      t_irq();
      conclude();
   end

   initial
   begin
      #500000;
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
